// ---- modem_setup_params.svh ----
`ifndef MODEM_SETUP_PARAMS_SVH
`define MODEM_SETUP_PARAMS_SVH

// ************************************************************
// serial control bus addresses
// ************************************************************
`define ADDR_GENERAL_RESET 8'h01
`define ADDR_SETUP_CONTROL 8'hE0
`define ADDR_TONE_CONTROL 8'hE1
`define ADDR_TX_DATA_BYTE 8'hE3

// ************************************************************
// field positions and reset values
// ************************************************************
`define SETUP_LOOP_HI 3
`define SETUP_LOOP_LO 2
`define SETUP_CLK_HI 1
`define SETUP_CLK_LO 0
`define TONE_ANSWER_SEL 7
`define TONE_ON 6
`define TONE_DUAL_MODE 5
`define TONE_SINGLE_TEST 4
`define TONE_CODE_HI 3
`define TONE_CODE_LO 0
`define SETUP_RESET 8'h00
`define TONE_RESET 8'h00

// ************************************************************
// divider ratios for the 3.6864, 7.3728 and 11.0592 MHz crystals
// ************************************************************
`define DIV_OFF 2'h0
`define DIV_XTAL_3M6864 2'h1
`define DIV_XTAL_7M3728 2'h2
`define DIV_XTAL_11M0592 2'h3

// ************************************************************
// tone frequencies in Hz
// ************************************************************
`define HZ_NONE 12'h000
`define HZ_697 12'h2b9
`define HZ_770 12'h302
`define HZ_852 12'h354
`define HZ_941 12'h3ad
`define HZ_1209 12'h4b9
`define HZ_1336 12'h538
`define HZ_1477 12'h5c5
`define HZ_1633 12'h661
`define HZ_550 12'h226
`define HZ_1300 12'h514
`define HZ_1800 12'h708
`define HZ_2100 12'h834
`define HZ_2225 12'h8b1

// ************************************************************
// timing
// ************************************************************
`define SYS_CLK_PERIOD_NS 5
`define MODEM_BIT_PERIOD_NS 833333

`endif

// ---- modem_setup_pkg.sv ----
`default_nettype none

package modem_setup_pkg;

  typedef enum logic [1:0] {
    ST_ADDR = 2'b01,
    ST_DATA = 2'b10
  } port_state_type;

  typedef enum logic [1:0] {
    LB_IDLE = 2'b01,
    LB_SHIFT = 2'b10
  } loop_state_type;

  typedef struct packed {
    logic [11:0] low_hz;
    logic [11:0] high_hz;
  } tone_pair_type;

endpackage

`default_nettype wire

// ---- ctrl_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface ctrl_bus_if;
  logic wr;
  logic gen_rst;
  logic [7:0] addr;
  logic [7:0] data;

  modport src (output wr, output gen_rst, output addr, output data);
  modport sink (input wr, input gen_rst, input addr, input data);
endinterface

`default_nettype wire

// ---- serial_ctrl_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "modem_setup_params.svh"

module serial_ctrl_port (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_sclk, // serial clock pin
  input wire logic i_csn, // chip select pin, low active
  input wire logic i_cmd_data, // serial command data pin
  ctrl_bus_if.src bus // decoded writes
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic csn_s1_r, csn_s2_r;
  logic dat_s1_r, dat_s2_r;
  modem_setup_pkg::port_state_type state_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;

  always_ff @(posedge i_sys_clk)
  begin
    sclk_s1_r <= i_sclk;
    sclk_s2_r <= sclk_s1_r;
    sclk_s3_r <= sclk_s2_r;
    csn_s1_r <= i_csn;
    csn_s2_r <= csn_s1_r;
    dat_s1_r <= i_cmd_data;
    dat_s2_r <= dat_s1_r;
  end

  // ************************************************************
  // byte assembly, msb first
  // ************************************************************
  wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
  wire bit_take = sclk_rise & ~csn_s2_r;
  wire [7:0] byte_nxt = {shift_r[6:0], dat_s2_r};
  wire byte_done = bit_take & (bit_cnt_r == 3'h7);
  wire is_gen_rst = byte_nxt == `ADDR_GENERAL_RESET;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst | csn_s2_r)
    begin
      state_r <= modem_setup_pkg::ST_ADDR;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      bus.wr <= 1'b0;
      bus.gen_rst <= 1'b0;
      if (i_rst)
      begin
        bus.addr <= 8'h00;
        bus.data <= 8'h00;
      end
    end
    else
    begin
      bus.wr <= 1'b0;
      bus.gen_rst <= 1'b0;
      if (bit_take)
      begin
        shift_r <= byte_nxt;
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (byte_done)
      begin
        unique case (state_r)
          modem_setup_pkg::ST_ADDR:
          begin
            // reset command carries no data byte
            if (is_gen_rst)
              bus.gen_rst <= 1'b1;
            else
            begin
              bus.addr <= byte_nxt;
              state_r <= modem_setup_pkg::ST_DATA;
            end
          end
          modem_setup_pkg::ST_DATA:
          begin
            bus.data <= byte_nxt;
            bus.wr <= 1'b1;
            state_r <= modem_setup_pkg::ST_ADDR;
          end
          default:
            state_r <= modem_setup_pkg::ST_ADDR;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ---- modem_setup_tone_control.sv ----
// Contract
// - loopback code 00 keeps normal signal paths; code 11 is reserved.
// - code 01 feeds transmit gain output to receive gain, opens op-amp path.
// - code 10 loops transmit bytes bitwise into receive buffer, sets ready.
// - clock select 01, 10, 11 pick dividers for the three crystals.
// - clock select 00 stops oscillator, bias, all but port and ring detect; here o_analog_loop and o_rx_opamp_break still follow code 01.
// - tone bit 7 picks answer detector frequency: 0 is 2225, 1 is 2100 Hz.
// - tone bit 6 sends the tone, else bias; host sets frequency first.
// - tone bit 5 set selects DTMF, clear selects modem progress tones.
// - tone bit 4 set gives only one frequency of the selected pair.
// - DTMF code picks keypad pair; single mode 0-7 upper, 8-15 lower.
// - progress codes 0-4 give 550, 1300, 1800, 2100, 2225 Hz.
// - general reset command clears every write-only control bit.
`timescale 1ns/1ps
`default_nettype none
`include "modem_setup_params.svh"

module modem_setup_tone_control #(
  parameter int unsigned BIT_CYCLES =
    `MODEM_BIT_PERIOD_NS / `SYS_CLK_PERIOD_NS
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_sclk, // serial control clock pin
  input wire logic i_csn, // serial control select, low active
  input wire logic i_cmd_data, // serial command data pin
  input wire logic i_rx_read, // receive byte read pulse
  output logic o_analog_loop, // tx gain out to rx gain in
  output logic o_rx_opamp_break, // rx op-amp disconnected
  output logic o_digital_loop, // digital loopback active
  output logic o_zero_power, // zero-power mode
  output logic o_osc_enable, // crystal oscillator on
  output logic o_bias_enable, // bias chain connected
  output logic [1:0] o_clk_div, // divider ratio, 0 when off
  output logic [11:0] o_answer_hz, // answer detector frequency
  output logic o_tone_on, // tone transmitted, else bias
  output logic o_tone_dtmf, // generator in dtmf mode
  output logic [11:0] o_tone_low_hz, // lower tone, 0 if none
  output logic [11:0] o_tone_high_hz, // upper tone, 0 if none
  output logic o_tx_ready, // transmit holding empty
  output logic o_rx_ready, // receive byte waiting
  output logic [7:0] o_rx_byte // receive holding byte
);

  // ************************************************************
  // control port
  // ************************************************************
  ctrl_bus_if bus ();

  serial_ctrl_port u_port (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_sclk(i_sclk),
    .i_csn(i_csn),
    .i_cmd_data(i_cmd_data),
    .bus(bus.src)
  );

  // ************************************************************
  // write-only registers
  // ************************************************************
  logic [7:0] setup_control_r;
  logic [7:0] tone_transmit_control_r;
  wire clr_all = i_rst | bus.gen_rst;
  wire wr_setup = bus.wr & (bus.addr == `ADDR_SETUP_CONTROL);
  wire wr_tone = bus.wr & (bus.addr == `ADDR_TONE_CONTROL);
  wire wr_txdata = bus.wr & (bus.addr == `ADDR_TX_DATA_BYTE);

  always_ff @(posedge i_sys_clk)
  begin
    if (clr_all)
    begin
      setup_control_r <= `SETUP_RESET;
      tone_transmit_control_r <= `TONE_RESET;
    end
    else
    begin
      if (wr_setup)
        setup_control_r <= bus.data;
      if (wr_tone)
        tone_transmit_control_r <= bus.data;
    end
  end

  // ************************************************************
  // setup decode
  // ************************************************************
  wire loopback_sel_hi = setup_control_r[`SETUP_LOOP_HI];
  wire loopback_sel_lo = setup_control_r[`SETUP_LOOP_LO];
  wire clock_sel_hi = setup_control_r[`SETUP_CLK_HI];
  wire clock_sel_lo = setup_control_r[`SETUP_CLK_LO];
  // 00 and reserved 11 both leave the paths untouched
  wire analog_loop = ~loopback_sel_hi & loopback_sel_lo;
  wire digital_loop = loopback_sel_hi & ~loopback_sel_lo;
  wire zero_power = ~clock_sel_hi & ~clock_sel_lo;
  wire [1:0] clk_div = zero_power ? `DIV_OFF :
    {clock_sel_hi, clock_sel_lo};

  // ************************************************************
  // tone decode
  // ************************************************************
  wire answer_freq_sel = tone_transmit_control_r[`TONE_ANSWER_SEL];
  wire tone_enable = tone_transmit_control_r[`TONE_ON];
  wire dual_tone_mode = tone_transmit_control_r[`TONE_DUAL_MODE];
  wire single_freq_test = tone_transmit_control_r[`TONE_SINGLE_TEST];
  wire [3:0] tone_code =
    tone_transmit_control_r[`TONE_CODE_HI:`TONE_CODE_LO];

  function automatic modem_setup_pkg::tone_pair_type keypad_pair(
    input logic [3:0] code
  );
    modem_setup_pkg::tone_pair_type p;
    p.low_hz = `HZ_NONE;
    p.high_hz = `HZ_NONE;
    unique case (code)
      4'h0: p = '{`HZ_941, `HZ_1633};
      4'h1: p = '{`HZ_697, `HZ_1209};
      4'h2: p = '{`HZ_697, `HZ_1336};
      4'h3: p = '{`HZ_697, `HZ_1477};
      4'h4: p = '{`HZ_770, `HZ_1209};
      4'h5: p = '{`HZ_770, `HZ_1336};
      4'h6: p = '{`HZ_770, `HZ_1477};
      4'h7: p = '{`HZ_852, `HZ_1209};
      4'h8: p = '{`HZ_852, `HZ_1336};
      4'h9: p = '{`HZ_852, `HZ_1477};
      4'hA: p = '{`HZ_941, `HZ_1336};
      4'hB: p = '{`HZ_941, `HZ_1209};
      4'hC: p = '{`HZ_941, `HZ_1477};
      4'hD: p = '{`HZ_697, `HZ_1633};
      4'hE: p = '{`HZ_770, `HZ_1633};
      4'hF: p = '{`HZ_852, `HZ_1633};
    endcase
    return p;
  endfunction

  function automatic logic [11:0] progress_hz(input logic [3:0] code);
    logic [11:0] f;
    f = `HZ_NONE;
    unique case (code)
      4'h0: f = `HZ_550;
      4'h1: f = `HZ_1300;
      4'h2: f = `HZ_1800;
      4'h3: f = `HZ_2100;
      4'h4: f = `HZ_2225;
      default: f = `HZ_NONE;
    endcase
    return f;
  endfunction

  wire modem_setup_pkg::tone_pair_type pair = keypad_pair(tone_code);
  // single test keeps the upper tone for codes 0-7, lower for 8-15
  wire [11:0] dtmf_low = (single_freq_test & ~tone_code[3]) ?
    `HZ_NONE : pair.low_hz;
  wire [11:0] dtmf_high = (single_freq_test & tone_code[3]) ?
    `HZ_NONE : pair.high_hz;
  wire [11:0] tone_low = dual_tone_mode ? dtmf_low : `HZ_NONE;
  wire [11:0] tone_high = dual_tone_mode ? dtmf_high :
    progress_hz(tone_code);
  // a silent code keeps the output at bias even with the tone bit set
  wire tone_on = tone_enable & ~zero_power &
    ((tone_low != `HZ_NONE) | (tone_high != `HZ_NONE));
  wire [11:0] answer_hz = answer_freq_sel ? `HZ_2100 : `HZ_2225;

  // ************************************************************
  // digital loopback serialiser
  // ************************************************************
  modem_setup_pkg::loop_state_type lb_state_r;
  logic [7:0] tx_hold_r, tx_shift_r, rx_shift_r;
  logic tx_full_r;
  logic [2:0] lb_bit_r;
  logic [17:0] baud_r;
  wire baud_end = baud_r == 18'(BIT_CYCLES - 1);
  wire lb_start = digital_loop & ~zero_power & tx_full_r &
    (lb_state_r == modem_setup_pkg::LB_IDLE);
  wire lb_last = (lb_state_r == modem_setup_pkg::LB_SHIFT) & baud_end &
    (lb_bit_r == 3'h7);
  // receive byte lands lsb first, as the modulator would send it
  wire [7:0] rx_assembled = {tx_shift_r[0], rx_shift_r[7:1]};

  always_ff @(posedge i_sys_clk)
  begin
    if (clr_all | ~digital_loop | zero_power)
    begin
      lb_state_r <= modem_setup_pkg::LB_IDLE;
      baud_r <= 18'h0_0000;
      lb_bit_r <= 3'h0;
      tx_shift_r <= 8'h00;
      rx_shift_r <= 8'h00;
    end
    else
    begin
      unique case (lb_state_r)
        modem_setup_pkg::LB_IDLE:
          if (lb_start)
          begin
            tx_shift_r <= tx_hold_r;
            baud_r <= 18'h0_0000;
            lb_bit_r <= 3'h0;
            lb_state_r <= modem_setup_pkg::LB_SHIFT;
          end
        modem_setup_pkg::LB_SHIFT:
        begin
          baud_r <= baud_end ? 18'h0_0000 : baud_r + 18'h0_0001;
          if (baud_end)
          begin
            rx_shift_r <= rx_assembled;
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            lb_bit_r <= lb_bit_r + 3'h1;
            if (lb_bit_r == 3'h7)
              lb_state_r <= modem_setup_pkg::LB_IDLE;
          end
        end
        default:
          lb_state_r <= modem_setup_pkg::LB_IDLE;
      endcase
    end
  end

  // a write while still full simply replaces the waiting byte
  always_ff @(posedge i_sys_clk)
  begin
    if (clr_all)
    begin
      tx_hold_r <= 8'h00;
      tx_full_r <= 1'b0;
    end
    else
    begin
      if (wr_txdata)
        tx_hold_r <= bus.data;
      if (wr_txdata)
        tx_full_r <= 1'b1;
      else if (lb_start)
        tx_full_r <= 1'b0;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_rx_ready <= 1'b0;
      o_rx_byte <= 8'h00;
    end
    else
    begin
      // a new byte wins over a read in the same cycle
      if (lb_last)
        o_rx_ready <= 1'b1;
      else if (i_rx_read)
        o_rx_ready <= 1'b0;
      if (lb_last)
        o_rx_byte <= rx_assembled;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_analog_loop <= 1'b0;
      o_rx_opamp_break <= 1'b0;
      o_digital_loop <= 1'b0;
      o_zero_power <= 1'b1;
      o_osc_enable <= 1'b0;
      o_bias_enable <= 1'b0;
      o_clk_div <= `DIV_OFF;
      o_answer_hz <= `HZ_2225;
      o_tone_on <= 1'b0;
      o_tone_dtmf <= 1'b0;
      o_tone_low_hz <= `HZ_NONE;
      o_tone_high_hz <= `HZ_NONE;
      o_tx_ready <= 1'b1;
    end
    else
    begin
      o_analog_loop <= analog_loop;
      o_rx_opamp_break <= analog_loop;
      o_digital_loop <= digital_loop;
      o_zero_power <= zero_power;
      o_osc_enable <= ~zero_power;
      o_bias_enable <= ~zero_power;
      o_clk_div <= clk_div;
      o_answer_hz <= answer_hz;
      o_tone_on <= tone_on;
      o_tone_dtmf <= dual_tone_mode;
      o_tone_low_hz <= tone_low;
      o_tone_high_hz <= tone_high;
      o_tx_ready <= ~tx_full_r;
    end
  end

endmodule

`default_nettype wire

// ---- modem_setup_tone_control_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module modem_setup_tone_control_properties (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rst, // sync reset
  input wire logic i_rx_read, // receive read pulse
  input wire logic o_analog_loop, // analogue loop
  input wire logic o_rx_opamp_break, // op-amp path broken
  input wire logic o_digital_loop, // digital loop
  input wire logic o_zero_power, // zero power
  input wire logic o_osc_enable, // oscillator on
  input wire logic o_bias_enable, // bias on
  input wire logic [1:0] o_clk_div, // divider
  input wire logic [11:0] o_answer_hz, // answer detector
  input wire logic o_tone_on, // tone sent
  input wire logic o_tone_dtmf, // dtmf mode
  input wire logic [11:0] o_tone_low_hz, // lower tone
  input wire logic [11:0] o_tone_high_hz, // upper tone
  input wire logic o_rx_ready, // receive byte waiting
  input wire logic [7:0] o_rx_byte // receive byte
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  // ****************************************
  // power, clock and loop paths
  // ****************************************
  a_zero_power_off: assert property (o_zero_power |-> !o_osc_enable &&
    !o_bias_enable && o_clk_div == 2'h0) else $error("zero power leak");
  a_clk_div_live: assert property (!o_zero_power |-> o_clk_div != 2'h0)
    else $error("divider off while powered");
  a_analog_pair: assert property (o_analog_loop == o_rx_opamp_break)
    else $error("analogue loop halves differ");
  a_loop_exclusive: assert property (!(o_analog_loop && o_digital_loop))
    else $error("two loopbacks at once");
  a_reset_values: assert property (disable iff (1'b0) i_rst [*3] |->
    o_zero_power && !o_tone_on && !o_rx_ready && o_answer_hz == 12'h8b1)
    else $error("reset values wrong");

  // ****************************************
  // tones and receive holding
  // ****************************************
  a_answer_values: assert property (o_answer_hz == 12'h834 ||
    o_answer_hz == 12'h8b1) else $error("answer frequency illegal");
  a_tone_needs_freq: assert property (o_tone_on |-> !o_zero_power &&
    (o_tone_low_hz != 12'h000 || o_tone_high_hz != 12'h000))
    else $error("tone on without frequency");
  a_progress_single: assert property (!o_tone_dtmf |->
    o_tone_low_hz == 12'h000) else $error("progress tone has lower tone");
  a_dtmf_some_freq: assert property (o_tone_dtmf |->
    o_tone_low_hz != 12'h000 || o_tone_high_hz != 12'h000)
    else $error("dtmf code with no frequency");
  a_rx_ready_hold: assert property (o_rx_ready && !i_rx_read |=>
    o_rx_ready) else $error("receive flag lost without read");
  a_rx_byte_flag: assert property ($changed(o_rx_byte) |-> o_rx_ready)
    else $error("receive byte changed without flag");

  c_tone_on: cover property (o_tone_on);
  c_rx_ready: cover property ($rose(o_rx_ready));
  c_analog: cover property (o_analog_loop);
  c_digital: cover property (o_digital_loop && !o_zero_power);
endmodule

`default_nettype wire

// ---- host_serial_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "modem_setup_params.svh"

module host_serial_model #(
  parameter int SETTLE_CYCLES = 100
) (
  input wire logic i_sys_clk, // system clock
  output logic o_sclk, // serial clock
  output logic o_csn, // select, low active
  output logic o_cmd_data // serial data
);
  // serial clock stands still between frames
  initial
  begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_cmd_data = 1'b1;
  end

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge i_sys_clk) o_cmd_data = b[i];
      repeat (8) @(negedge i_sys_clk);
      o_sclk = 1'b1;
      repeat (8) @(negedge i_sys_clk);
      o_sclk = 1'b0;
    end
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       input bit has_d);
    @(negedge i_sys_clk) o_csn = 1'b0;
    repeat (4) @(negedge i_sys_clk);
    send_byte(a);
    if (has_d)
      send_byte(d);
    repeat (4) @(negedge i_sys_clk);
    o_csn = 1'b1;
    // released line must not keep showing the last bit
    o_cmd_data = ~o_cmd_data;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    frame(a, d, 1'b1);
  endtask

  task automatic gen_reset;
    frame(`ADDR_GENERAL_RESET, 8'h00, 1'b0);
  endtask

  // frequency first, then switch the tone on
  task automatic tone(input logic [7:0] v);
    wr(`ADDR_TONE_CONTROL, v & 8'hbf);
    wr(`ADDR_TONE_CONTROL, v);
  endtask

  task automatic load_tx(input logic [7:0] b);
    wr(`ADDR_TX_DATA_BYTE, b);
  endtask

  // scaled stand-in for the oscillator restart time
  task automatic settle;
    repeat (SETTLE_CYCLES) @(negedge i_sys_clk);
  endtask
endmodule

`default_nettype wire

// ---- modem_setup_tone_control_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "modem_setup_params.svh"

module modem_setup_tone_control_tb_top;
  logic sys_clk, rst, sclk, csn, cmd_data, rx_read;
  logic analog_loop, opamp_break, digital_loop, zero_power;
  logic osc_en, bias_en, tone_on, tone_dtmf, tx_ready, rx_ready;
  logic [1:0] clk_div;
  logic [11:0] answer_hz, tone_lo, tone_hi;
  logic [7:0] rx_byte;
  int failures = 0;
  int total_checks = 0;
  logic [11:0] dl [16] = '{12'h3ad, 12'h2b9, 12'h2b9, 12'h2b9, 12'h302,
    12'h302, 12'h302, 12'h354, 12'h354, 12'h354, 12'h3ad, 12'h3ad, 12'h3ad,
    12'h2b9, 12'h302, 12'h354};
  logic [11:0] dh [16] = '{12'h661, 12'h4b9, 12'h538, 12'h5c5, 12'h4b9,
    12'h538, 12'h5c5, 12'h4b9, 12'h538, 12'h5c5, 12'h538, 12'h4b9, 12'h5c5,
    12'h661, 12'h661, 12'h661};
  logic [11:0] pg [5] = '{12'h226, 12'h514, 12'h708, 12'h834, 12'h8b1};

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  host_serial_model i_host (.i_sys_clk(sys_clk), .o_sclk(sclk),
    .o_csn(csn), .o_cmd_data(cmd_data));

  modem_setup_tone_control #(.BIT_CYCLES(4)) i_dut (.i_sys_clk(sys_clk),
    .i_rst(rst), .i_sclk(sclk), .i_csn(csn), .i_cmd_data(cmd_data),
    .i_rx_read(rx_read), .o_analog_loop(analog_loop),
    .o_rx_opamp_break(opamp_break), .o_digital_loop(digital_loop),
    .o_zero_power(zero_power), .o_osc_enable(osc_en),
    .o_bias_enable(bias_en), .o_clk_div(clk_div), .o_answer_hz(answer_hz),
    .o_tone_on(tone_on), .o_tone_dtmf(tone_dtmf), .o_tone_low_hz(tone_lo),
    .o_tone_high_hz(tone_hi), .o_tx_ready(tx_ready), .o_rx_ready(rx_ready),
    .o_rx_byte(rx_byte));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // decoded write reaches the outputs within a few cycles
  task automatic settle;
    repeat (12) @(negedge sys_clk);
  endtask

  // {lower, upper} expected for a tone register value
  function automatic logic [23:0] tone_exp(input logic [7:0] v);
    logic [11:0] lo;
    logic [11:0] hi;
    lo = 12'h000;
    hi = (v[3:0] < 4'h5) ? pg[v[2:0]] : 12'h000;
    if (v[5])
    begin
      lo = dl[v[3:0]];
      hi = dh[v[3:0]];
      if (v[4] && !v[3])
        lo = 12'h000;
      else if (v[4])
        hi = 12'h000;
    end
    return {lo, hi};
  endfunction

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [7:0] v;
    logic [23:0] e;
    logic [7:0] b;
    rst = 1'b1;
    rx_read = 1'b0;
    void'($urandom(32'h97f3));
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk({zero_power, osc_en, clk_div}, 4'h8);
    chk({tx_ready, rx_ready}, 2'h2);
    for (int s = 0; s < 16; s++)
    begin
      i_host.wr(`ADDR_SETUP_CONTROL, 8'(s));
      settle;
      chk(zero_power, s[1:0] == 2'h0);
      chk({osc_en, bias_en}, {2{s[1:0] != 2'h0}});
      chk(clk_div, s[1:0]);
      if (s[1:0] != 2'h0)
      begin
        chk({analog_loop, opamp_break}, {2{s[3:2] == 2'h1}});
        chk(digital_loop, s[3:2] == 2'h2);
      end
    end
    i_host.wr(`ADDR_SETUP_CONTROL, 8'h01);
    i_host.settle;
    for (int m = 0; m < 3; m++)
      for (int c = 0; c < 16; c++)
      begin
        v = {2'($urandom), (m == 0) ? 2'h2 : (m == 1) ? 2'h3 : 2'h0, 4'(c)};
        i_host.tone(v);
        settle;
        e = tone_exp(v);
        chk(answer_hz, v[7] ? 12'h834 : 12'h8b1);
        chk(tone_dtmf, v[5]);
        chk(tone_lo, e[23:12]);
        chk(tone_hi, e[11:0]);
        chk(tone_on, v[6] && e != 24'h0);
      end
    // a powered-down generator must stay silent
    i_host.wr(`ADDR_SETUP_CONTROL, 8'h00);
    i_host.tone(8'h61);
    settle;
    chk(tone_on, 1'b0);
    i_host.wr(`ADDR_SETUP_CONTROL, 8'h05);
    i_host.settle;
    i_host.tone(8'he1);
    settle;
    chk({analog_loop, tone_on, tone_dtmf}, 3'h7);
    i_host.gen_reset;
    settle;
    chk({zero_power, analog_loop, tone_on, tone_dtmf}, 4'h8);
    chk(answer_hz, 12'h8b1);
    i_host.wr(`ADDR_SETUP_CONTROL, 8'h09);
    i_host.settle;
    for (int n = 0; n < 4; n++)
    begin
      b = (n == 0) ? 8'h80 : (n == 1) ? 8'h01 : 8'($urandom);
      i_host.load_tx(b);
      for (int t = 0; t < 400 && rx_ready !== 1'b1; t++)
        @(negedge sys_clk);
      chk(rx_ready, 1'b1);
      if (rx_ready !== 1'b1)
        final_report;
      chk(rx_byte, b);
      chk(tx_ready, 1'b1);
      rx_read = 1'b1;
      @(negedge sys_clk);
      rx_read = 1'b0;
      @(negedge sys_clk);
      chk(rx_ready, 1'b0);
    end
    final_report;
  end
endmodule

bind modem_setup_tone_control modem_setup_tone_control_properties i_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_rx_read(i_rx_read),
  .o_analog_loop(o_analog_loop), .o_rx_opamp_break(o_rx_opamp_break),
  .o_digital_loop(o_digital_loop), .o_zero_power(o_zero_power),
  .o_osc_enable(o_osc_enable), .o_bias_enable(o_bias_enable),
  .o_clk_div(o_clk_div), .o_answer_hz(o_answer_hz), .o_tone_on(o_tone_on),
  .o_tone_dtmf(o_tone_dtmf), .o_tone_low_hz(o_tone_low_hz),
  .o_tone_high_hz(o_tone_high_hz), .o_rx_ready(o_rx_ready),
  .o_rx_byte(o_rx_byte));

`default_nettype wire
